/* File: dv/ctf_host_model.sv */
// storage controller model: drives arming, supply-good and dram self-refresh
`timescale 1ns/1ps
module ctf_host_model (
    input  wire logic clk_i,
    output logic      writeback_armed_o,
    output logic      supply_good_o,
    output logic      self_refresh_o
);
    // host levels move just after the clock edge, never on it
    task automatic tick();
        @(posedge clk_i);
        #1;
    endtask

    // power applied: host holds arming low before any cache check
    task automatic power_on();
        writeback_armed_o = 1'b0;
        supply_good_o     = 1'b1;
        self_refresh_o    = 1'b0;
    endtask

    // arming follows the host's caching mode
    task automatic set_armed(input logic v);
        writeback_armed_o = v;
    endtask

    // dram parked in self-refresh a full cycle before supply drops
    task automatic power_fail();
        self_refresh_o = 1'b1;
        tick();
        supply_good_o = 1'b0;
    endtask

    // supply returns; dram leaves self-refresh with it
    task automatic power_back();
        supply_good_o  = 1'b1;
        self_refresh_o = 1'b0;
    endtask

    // flush finished: arming pulsed high for cyc clocks, then low again
    task automatic pulse(input int unsigned cyc);
        writeback_armed_o = 1'b1;
        repeat (cyc) tick();
        writeback_armed_o = 1'b0;
    endtask
endmodule

/* File: dv/ctf_seq_test.sv */
// self-checking bench for the cache-to-flash backup sequencer
`timescale 1ns/1ps
module ctf_seq_test;
    import ctf_pkg::*;
    // power-up header and the state and status it must lead to
    typedef struct packed {
        ctf_hdr_t    hdr;
        ctf_state_t  st;
        ctf_status_t stat;
    } ctf_row_t;
    // the accepted erase pulse alone is over 100000 clocks, so allow margin
    localparam int CEIL = 120000;
    logic              clk_i;
    logic              rst_i;
    logic              armed, supply, refresh;
    ctf_hdr_t          hdr_i;
    logic              copy_last_i, hdr_wr_ack_i, erase_done_i, hk_done_i;
    logic [FIFO_W-1:0] src_data_i, dst_data_o;
    logic              src_valid_i, src_ready_o, dst_valid_o, dst_ready_i;
    ctf_status_t       status_o;
    ctf_hdr_wr_t       hdr_wr_o;
    logic              hdr_rd_o, copy_to_flash_o, copy_to_dram_o, erase_o, supply_off_o;
    logic [POS_W-1:0]  copy_pos_o;
    ctf_state_t        state_o;
    int                fails = 0;
    int                check_count = 0;
    int                cyc = 0;
    int                n;
    ctf_row_t          rows [4] = '{
        '{3'h7, CTF_RESTORE, 3'h1},
        '{3'h6, CTF_RESTORE, 3'h1},
        '{3'h4, CTF_ERASE,   3'h2},
        '{3'h5, CTF_IDLE,    3'h6}
    };

    ctf_seq u_ctf_seq (.clk_i(clk_i), .rst_i(rst_i), .writeback_armed_i(armed),
        .supply_good_i(supply), .hdr_i(hdr_i), .copy_last_i(copy_last_i),
        .hdr_wr_ack_i(hdr_wr_ack_i), .erase_done_i(erase_done_i), .hk_done_i(hk_done_i),
        .src_data_i(src_data_i), .src_valid_i(src_valid_i), .src_ready_o(src_ready_o),
        .dst_data_o(dst_data_o), .dst_valid_o(dst_valid_o), .dst_ready_i(dst_ready_i),
        .status_o(status_o), .hdr_wr_o(hdr_wr_o), .hdr_rd_o(hdr_rd_o),
        .copy_to_flash_o(copy_to_flash_o), .copy_to_dram_o(copy_to_dram_o),
        .erase_o(erase_o), .copy_pos_o(copy_pos_o), .supply_off_o(supply_off_o),
        .state_o(state_o));
    ctf_host_model u_ctf_host_model (.clk_i(clk_i), .writeback_armed_o(armed),
        .supply_good_o(supply), .self_refresh_o(refresh));

    // 250 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    // hang guard: a run past the ceiling counts as a failure
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == CEIL) begin
            fails++;
            close_out();
        end
    end

    task automatic close_out();
        if (fails == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // all bench drives land 1 ns after the rising edge
    task automatic tick();
        @(posedge clk_i);
        #1;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // bounded wait for a state, then compare it
    task automatic wait_st(input ctf_state_t s, input int lim);
        int k;
        k = 0;
        while (state_o !== s && k < lim) begin
            tick();
            k++;
        end
        chk(state_o, s);
    endtask

    // reset for two clocks with every flash-side input quiet except dst_ready_i, held high
    task automatic do_reset();
        rst_i        = 1'b1;
        hdr_i        = '0;
        copy_last_i  = 1'b0;
        hdr_wr_ack_i = 1'b0;
        erase_done_i = 1'b0;
        hk_done_i    = 1'b0;
        src_data_i   = '0;
        src_valid_i  = 1'b0;
        dst_ready_i  = 1'b1;
        u_ctf_host_model.power_on();
        tick();
        tick();
        rst_i = 1'b0;
        chk(state_o, CTF_PWRUP);
        chk(status_o, '0);
        chk(supply_off_o, 1'b0);
        chk(copy_pos_o, '0);
        chk(hdr_rd_o, 1'b1);
    endtask

    // one word: valid held until ready is seen at an edge
    task automatic send(input logic [FIFO_W-1:0] d, input logic last);
        int k;
        k = 0;
        src_data_i  = d;
        copy_last_i = last;
        src_valid_i = 1'b1;
        #2;
        while (src_ready_o !== 1'b1 && k < 50) begin
            tick();
            #2;
            k++;
        end
        tick();
        src_valid_i = 1'b0;
        copy_last_i = 1'b0;
    endtask

    task automatic ack_hdr();
        hdr_wr_ack_i = 1'b1;
        tick();
        hdr_wr_ack_i = 1'b0;
    endtask

    initial begin
        do_reset();
        // ordinary power-up outcomes from the header table
        foreach (rows[i]) begin
            do_reset();
            hdr_i = rows[i].hdr;
            wait_st(rows[i].st, 20);
            chk(status_o, rows[i].stat);
        end
        // clean idle, supply lost: no copy, then battery switched off
        do_reset();
        hdr_i = 3'h5;
        wait_st(CTF_IDLE, 20);
        u_ctf_host_model.power_fail();
        wait_st(CTF_PWRDN, 10);
        chk({copy_to_flash_o, hdr_wr_o}, '0);
        hk_done_i = 1'b1;
        tick();
        hk_done_i = 1'b0;
        tick();
        chk(supply_off_o, 1'b1);
        // arm, disarm, arm again, then power fail with a stalled far side
        do_reset();
        hdr_i = 3'h5;
        wait_st(CTF_IDLE, 20);
        u_ctf_host_model.set_armed(1'b1);
        wait_st(CTF_BACKUP, 10);
        chk(status_o, 3'h7);
        u_ctf_host_model.set_armed(1'b0);
        wait_st(CTF_IDLE, 10);
        chk(status_o, 3'h6);
        u_ctf_host_model.set_armed(1'b1);
        wait_st(CTF_BACKUP, 10);
        u_ctf_host_model.power_fail();
        tick();
        tick();
        chk(status_o.dram_available, 1'b0);
        chk(hdr_wr_o, 2'h2);
        chk(src_ready_o, 1'b0);
        chk(copy_to_flash_o, 1'b0);
        ack_hdr();
        repeat (3) tick();
        chk(copy_to_flash_o, 1'b1);
        // fill the fifo until it refuses, flash side stalled
        dst_ready_i = 1'b0;
        src_valid_i = 1'b1;
        n = 0;
        while (n < 40) begin
            src_data_i = FIFO_W'(n);
            #2;
            if (src_ready_o !== 1'b1) break;
            tick();
            n++;
        end
        tick();
        src_valid_i = 1'b0;
        chk(n, FIFO_D);
        chk(copy_pos_o, FIFO_D);
        // drain until empty, first word out must be the first word in
        dst_ready_i = 1'b1;
        #2;
        chk(dst_data_o, '0);
        n = 0;
        while (dst_valid_o === 1'b1 && n < 40) begin
            chk(dst_data_o, FIFO_W'(n));
            n++;
            tick();
            #2;
        end
        tick();
        chk(n, FIFO_D);
        // supply returns mid copy, then fails again: copy resumes in place
        u_ctf_host_model.power_back();
        wait_st(CTF_GLITCH, 10);
        chk(status_o, 3'h3);
        chk(copy_pos_o, FIFO_D);
        u_ctf_host_model.power_fail();
        wait_st(CTF_BACKUP, 10);
        send(32'h0000ABCD, 1'b1);
        repeat (3) tick();
        chk(hdr_wr_o, 2'h1);
        ack_hdr();
        wait_st(CTF_PWRDN, 10);
        chk(copy_pos_o, FIFO_D + 1);
        // dirty power-up: restore, short pulse ignored, long pulse erases
        do_reset();
        hdr_i = 3'h6;
        wait_st(CTF_RESTORE, 20);
        chk(status_o, 3'h1);
        chk(copy_to_dram_o, 1'b1);
        send(32'h00000001, 1'b0);
        tick();
        send(32'h00000002, 1'b1);
        repeat (3) tick();
        chk(status_o, 3'h3);
        chk(copy_to_dram_o, 1'b0);
        chk(src_ready_o, 1'b0);
        u_ctf_host_model.pulse(3);
        tick();
        chk(state_o, CTF_RESTORE);
        u_ctf_host_model.pulse(1000);
        repeat (3) tick();
        chk(state_o, CTF_RESTORE);
        u_ctf_host_model.pulse(PULSE_MIN_CYC + 1000);
        wait_st(CTF_ERASE, 10);
        chk(status_o, 3'h2);
        chk(erase_o, 1'b1);
        erase_done_i = 1'b1;
        tick();
        erase_done_i = 1'b0;
        wait_st(CTF_IDLE, 10);
        chk(status_o, 3'h6);
        // supply lost mid restore
        do_reset();
        hdr_i = 3'h6;
        wait_st(CTF_RESTORE, 20);
        u_ctf_host_model.power_fail();
        wait_st(CTF_PWRDN, 10);
        close_out();
    end
endmodule

/* File: verilog/ctf_fifo.sv */
// parameterised flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
module ctf_fifo #(
    parameter int unsigned WIDTH = 32,
    parameter int unsigned DEPTH = 32
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    output logic      [WIDTH-1:0] out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];   // storage
    logic [AW-1:0]    wp_q, wp_d;      // write index
    logic [AW-1:0]    rp_q, rp_d;      // read index
    logic [AW:0]      cnt_q, cnt_d;    // fill level
    logic             push, pop;

    assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o  = mem_q[rp_q];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    // index and level update
    always_comb begin
        wp_d  = push ? AW'(wp_q + 1'b1) : wp_q;
        rp_d  = pop ? AW'(rp_q + 1'b1) : rp_q;
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = (AW+1)'(cnt_q + 1'b1);
        end else if (pop && !push) begin
            cnt_d = (AW+1)'(cnt_q - 1'b1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            wp_q  <= wp_d;
            rp_q  <= rp_d;
            cnt_q <= cnt_d;
        end
    end

    // storage holds no reset; contents are qualified by the level
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_q[wp_q] <= in_data_i;
        end
    end
endmodule

/* File: verilog/ctf_pkg.sv */
// package with states, structs and timing constants of the backup sequencer
package ctf_pkg;
    // clock rate and times
    localparam int unsigned CLK_MHZ        = 250;    // system clock in MHz
    localparam int unsigned PULSE_US       = 500;    // erase request pulse width, us
    localparam int unsigned PULSE_MIN_US   = 400;    // shortest pulse accepted, us
    localparam int unsigned PULSE_MIN_CYC  = PULSE_MIN_US * CLK_MHZ;   // least time, exact
    localparam int unsigned PULSE_MAX_US   = 600;    // longest pulse accepted, us
    localparam int unsigned PULSE_MAX_CYC  = PULSE_MAX_US * CLK_MHZ;
    localparam int unsigned PW_W           = 18;     // pulse width counter width
    localparam int unsigned FIFO_W         = 32;     // data word width
    localparam int unsigned FIFO_D         = 32;     // fifo depth
    localparam int unsigned POS_W          = 32;     // copy position width

    // sequencer states
    typedef enum logic [2:0] {
        CTF_PWRUP   = 3'h0,
        CTF_IDLE    = 3'h1,
        CTF_BACKUP  = 3'h2,
        CTF_RESTORE = 3'h3,
        CTF_ERASE   = 3'h4,
        CTF_GLITCH  = 3'h5,
        CTF_PWRDN   = 3'h6
    } ctf_state_t;

    // flash header status read at power-up
    typedef struct packed {
        logic valid;      // header read finished
        logic dirty;      // saved cache data exists
        logic erased;     // flash erased and initialised
    } ctf_hdr_t;

    // header write requests
    typedef struct packed {
        logic start;      // write copy-begun marker
        logic done;       // write copy-complete marker
    } ctf_hdr_wr_t;

    // status outputs towards the controller
    typedef struct packed {
        logic backup_ready;
        logic dram_available;
        logic pending_data_flag;
    } ctf_status_t;
endpackage

/* File: verilog/ctf_seq.sv */
// cache-to-flash backup and restore sequencer
`timescale 1ns/1ps
// How it works
// (R1) host holds armed low during power-up
// (R2) dirty cache: host keeps armed low until flushed
// (R3) host pulses armed 500us to request erase
// (R4) header read at power-up sets pending flag
// (R5) host puts dram in self-refresh first
// (R6) dirty header: flag on, others off, restore
// (R7) clean unerased: dram on, erase state
// (R8) clean erased: dram, ready on, idle
// (R9) idle supply loss: power down, no copy
// (R10) armed in idle: backup, flag set
// (R11) armed drop in backup: clear flag, idle
// (R12) supply loss in backup: dram off, copy
// (R13) copy done: header status, then power down
// (R14) supply back mid copy: pause, glitch
// (R15) glitch: dram on, ready off, wait
// (R16) glitch supply loss: resume copy
// (R17) glitch pulse: clear flag, erase
// (R18) erase flash, then ready on, idle
// (R19) restore keeps dram off until done
// (R20) restore then pulse: clear flag, erase
// (R21) supply loss in restore: power down
// (R22) power down: housekeeping then supply off
// (R23) begun marker before copy, done after
// (R24) ready means flash erased and accepting copy
// (R25) pulse width counted, short glitches ignored
module ctf_seq
    import ctf_pkg::*;
(
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    input  wire logic                writeback_armed_i,  // host arming level
    input  wire logic                supply_good_i,      // system power good
    input  wire ctf_pkg::ctf_hdr_t   hdr_i,              // header status from flash side
    input  wire logic                copy_last_i,        // last word of image
    input  wire logic                hdr_wr_ack_i,       // header write finished
    input  wire logic                erase_done_i,       // flash erase and init done
    input  wire logic                hk_done_i,          // housekeeping finished
    // dram-to-flash stream in (backup) or flash-to-dram stream (restore)
    input  wire logic [ctf_pkg::FIFO_W-1:0] src_data_i,
    input  wire logic                src_valid_i,
    output logic                     src_ready_o,
    output logic [ctf_pkg::FIFO_W-1:0] dst_data_o,
    output logic                     dst_valid_o,
    input  wire logic                dst_ready_i,
    output ctf_pkg::ctf_status_t     status_o,           // ready, dram, pending flag
    output ctf_pkg::ctf_hdr_wr_t     hdr_wr_o,           // header marker requests
    output logic                     hdr_rd_o,           // header read request
    output logic                     copy_to_flash_o,    // backup copy running
    output logic                     copy_to_dram_o,     // restore copy running
    output logic                     erase_o,            // erase request level
    output logic [ctf_pkg::POS_W-1:0] copy_pos_o,        // words moved so far
    output logic                     supply_off_o,       // switch off backup power
    output ctf_pkg::ctf_state_t      state_o
);
    ctf_state_t  st_q, st_d;            // sequencer state
    ctf_status_t stat_q, stat_d;        // registered status outputs
    logic        began_q, began_d;      // begun marker written
    logic        done_mk_q, done_mk_d;  // copy finished, completion marker pending
    logic        off_q, off_d;          // supply cut-off
    logic [POS_W-1:0] pos_q, pos_d;     // copy position kept across a glitch
    logic [PW_W-1:0]  pw_q, pw_d;       // armed high-time counter
    logic        arm_q;                 // armed delayed one cycle
    logic        pulse_ok;              // valid erase pulse just ended
    logic        copy_en;               // stream may move
    logic        fifo_in_ready;
    logic        push_fire;

    // pulse width measure; a pulse counts only in the accepted window
    always_comb begin
        pw_d = pw_q;
        if (writeback_armed_i) begin
            if (pw_q != PW_W'(PULSE_MAX_CYC + 1)) begin
                pw_d = PW_W'(pw_q + 1'b1);
            end
        end else begin
            pw_d = '0;
        end
    end
    assign pulse_ok = arm_q && !writeback_armed_i &&
                      (pw_q >= PW_W'(PULSE_MIN_CYC)) &&
                      (pw_q <= PW_W'(PULSE_MAX_CYC));      // R25

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pw_q  <= '0;
            arm_q <= 1'b0;
        end else begin
            pw_q  <= pw_d;
            arm_q <= writeback_armed_i;
        end
    end

    // the stream moves only in copy states with markers in order;
    // the position survives a pause so the glitch resume continues in place
    assign copy_en   = ((st_q == CTF_BACKUP) && !supply_good_i && began_q && !done_mk_q) ||
                       ((st_q == CTF_RESTORE) && supply_good_i && !stat_q.dram_available);
    assign src_ready_o = copy_en && fifo_in_ready;
    assign push_fire = src_valid_i && src_ready_o;

    // next-state and output logic
    always_comb begin
        st_d      = st_q;
        stat_d    = stat_q;
        began_d   = began_q;
        done_mk_d = done_mk_q;
        off_d     = off_q;
        pos_d     = push_fire ? POS_W'(pos_q + 1'b1) : pos_q;
        case (st_q)
            CTF_PWRUP: begin
                stat_d = '0;
                if (hdr_i.valid) begin                     // R4
                    if (hdr_i.dirty) begin
                        stat_d = '{backup_ready: 1'b0, dram_available: 1'b0,
                                   pending_data_flag: 1'b1};        // R6
                        pos_d  = '0;
                        st_d   = CTF_RESTORE;
                    end else if (!hdr_i.erased) begin
                        stat_d = '{backup_ready: 1'b0, dram_available: 1'b1,
                                   pending_data_flag: 1'b0};        // R7
                        st_d   = CTF_ERASE;
                    end else begin
                        stat_d = '{backup_ready: 1'b1, dram_available: 1'b1,
                                   pending_data_flag: 1'b0};        // R8
                        st_d   = CTF_IDLE;
                    end
                end
            end
            CTF_IDLE: begin
                if (!supply_good_i) begin
                    st_d = CTF_PWRDN;                      // R9
                end else if (writeback_armed_i) begin
                    stat_d.pending_data_flag = 1'b1;       // R10
                    began_d   = 1'b0;
                    done_mk_d = 1'b0;
                    pos_d     = '0;
                    st_d      = CTF_BACKUP;
                end
            end
            CTF_BACKUP: begin
                if (supply_good_i) begin
                    if (began_q) begin
                        st_d = CTF_GLITCH;                 // R14
                        stat_d.dram_available = 1'b1;      // R15
                        stat_d.backup_ready   = 1'b0;
                    end else begin
                        // supply back before the begun marker: nothing moved yet,
                        // so dram and flash are handed back instead of staying locked
                        stat_d.dram_available = 1'b1;
                        stat_d.backup_ready   = 1'b1;
                        if (!writeback_armed_i) begin
                            stat_d.pending_data_flag = 1'b0;   // R11
                            st_d = CTF_IDLE;
                        end
                    end
                end else begin
                    stat_d.dram_available = 1'b0;          // R12
                    stat_d.backup_ready   = 1'b0;
                    if (!began_q && hdr_wr_ack_i) begin
                        began_d = 1'b1;                    // R23
                    end
                    if (push_fire && copy_last_i) begin
                        done_mk_d = 1'b1;
                    end
                    if (done_mk_q && hdr_wr_ack_i) begin
                        st_d = CTF_PWRDN;                  // R13
                    end
                end
            end
            CTF_GLITCH: begin
                if (!supply_good_i) begin
                    st_d = CTF_BACKUP;                     // R16
                    stat_d.dram_available = 1'b0;
                end else if (pulse_ok) begin
                    stat_d.pending_data_flag = 1'b0;       // R17
                    st_d = CTF_ERASE;
                end
            end
            CTF_ERASE: begin
                if (erase_done_i) begin
                    stat_d.backup_ready = 1'b1;            // R18 R24
                    st_d = CTF_IDLE;
                end
            end
            CTF_RESTORE: begin
                if (!supply_good_i) begin
                    st_d = CTF_PWRDN;                      // R21
                end else if (!stat_q.dram_available) begin
                    if (push_fire && copy_last_i) begin
                        stat_d.dram_available = 1'b1;      // R19
                    end
                end else if (pulse_ok) begin
                    stat_d.pending_data_flag = 1'b0;       // R20
                    st_d = CTF_ERASE;
                end
            end
            CTF_PWRDN: begin
                stat_d.dram_available = 1'b0;
                stat_d.backup_ready   = 1'b0;
                if (hk_done_i) begin
                    off_d = 1'b1;                          // R22
                end
            end
            default: begin
                st_d = CTF_PWRUP;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q      <= CTF_PWRUP;
            stat_q    <= '0;
            began_q   <= 1'b0;
            done_mk_q <= 1'b0;
            off_q     <= 1'b0;
            pos_q     <= '0;
        end else begin
            st_q      <= st_d;
            stat_q    <= stat_d;
            began_q   <= began_d;
            done_mk_q <= done_mk_d;
            off_q     <= off_d;
            pos_q     <= pos_d;
        end
    end

    // words pass a fifo so the receiving side (flash in backup, dram in restore) can stall the sending side
    ctf_fifo #(
        .WIDTH(FIFO_W),
        .DEPTH(FIFO_D)
    ) u_ctf_fifo (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .in_data_i  (src_data_i),
        .in_valid_i (src_valid_i && copy_en),
        .in_ready_o (fifo_in_ready),
        .out_data_o (dst_data_o),
        .out_valid_o(dst_valid_o),
        .out_ready_i(dst_ready_i)
    );

    assign status_o        = stat_q;
    assign state_o         = st_q;
    assign hdr_rd_o        = (st_q == CTF_PWRUP);
    assign hdr_wr_o.start  = (st_q == CTF_BACKUP) && !supply_good_i && !began_q;  // R23
    assign hdr_wr_o.done   = (st_q == CTF_BACKUP) && !supply_good_i && done_mk_q; // R23
    assign copy_to_flash_o = (st_q == CTF_BACKUP) && !supply_good_i && began_q && !done_mk_q;
    assign copy_to_dram_o  = (st_q == CTF_RESTORE) && !stat_q.dram_available;
    assign erase_o         = (st_q == CTF_ERASE);
    assign copy_pos_o      = pos_q;
    assign supply_off_o    = off_q;

    // checks
    property p_idle_loss;
        @(posedge clk_i) disable iff (rst_i)
        (st_q == CTF_IDLE && !supply_good_i) |=> (st_q == CTF_PWRDN);
    endproperty
    a_idle_loss: assert property (p_idle_loss) else $error("idle loss not power down"); // R9

    property p_arm;
        @(posedge clk_i) disable iff (rst_i)
        (st_q == CTF_IDLE && supply_good_i && writeback_armed_i) |=>
            (st_q == CTF_BACKUP && status_o.pending_data_flag);
    endproperty
    a_arm: assert property (p_arm) else $error("arming not taken"); // R10

    property p_disarm;
        @(posedge clk_i) disable iff (rst_i)
        (st_q == CTF_BACKUP && supply_good_i && !began_q && !writeback_armed_i) |=>
            (st_q == CTF_IDLE && !status_o.pending_data_flag);
    endproperty
    a_disarm: assert property (p_disarm) else $error("disarm not to idle"); // R11

    property p_dram_off;
        @(posedge clk_i) disable iff (rst_i)
        (st_q == CTF_BACKUP && !supply_good_i) |=> !status_o.dram_available;
    endproperty
    a_dram_off: assert property (p_dram_off) else $error("dram left available"); // R12

    property p_glitch;
        @(posedge clk_i) disable iff (rst_i)
        (st_q == CTF_BACKUP && supply_good_i && began_q) |=>
            (st_q == CTF_GLITCH && status_o.dram_available && !status_o.backup_ready
             && $stable(pos_q));
    endproperty
    a_glitch: assert property (p_glitch) else $error("glitch entry wrong"); // R14

    property p_resume;
        @(posedge clk_i) disable iff (rst_i)
        (st_q == CTF_GLITCH && !supply_good_i) |=> (st_q == CTF_BACKUP);
    endproperty
    a_resume: assert property (p_resume) else $error("no resume"); // R16

    sequence s_short_pulse;
        !writeback_armed_i ##1 writeback_armed_i [*3] ##1 !writeback_armed_i;
    endsequence
    property p_short;
        @(posedge clk_i) disable iff (rst_i)
        s_short_pulse |-> !pulse_ok;
    endproperty
    a_short: assert property (p_short) else $error("short pulse accepted"); // R25

    property p_restore_loss;
        @(posedge clk_i) disable iff (rst_i)
        (st_q == CTF_RESTORE && !supply_good_i) |=> (st_q == CTF_PWRDN);
    endproperty
    a_restore_loss: assert property (p_restore_loss) else $error("restore loss"); // R21

    property p_erase;
        @(posedge clk_i) disable iff (rst_i)
        (st_q == CTF_ERASE && erase_done_i) |=> (st_q == CTF_IDLE && status_o.backup_ready);
    endproperty
    a_erase: assert property (p_erase) else $error("erase exit wrong"); // R18
endmodule
